// ### core/circuit_breaker.sv
// fault latch, filters, integrator and arming of the two-channel breaker
`timescale 1ns/1ps
`default_nettype none
`include "breaker_cfg.svh"
module circuit_breaker #(
  parameter int OV_CNT = `OV_CYCLES,
  parameter int FLT_CNT = `FAULT_CYCLES,
  parameter int SLOW_CNT = `SLOW_CYCLES,
  parameter int FAST_CNT = `FAST_CYCLES,
  parameter int RST_CNT = `RESET_CYCLES,
  parameter int INTEG_TRIP = `INTEG_TRIP
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_master_enable_reset_low, // reset comparator: input below 0.4V
  input wire logic i_init_done, // initial timing cycle finished
  input wire logic i_startup_done, // start-up current loop disengaged
  input wire breaker_pkg::chan_t i_fb_over, // feedback above overvoltage level
  input wire breaker_pkg::chan_t i_slow_over, // sense above 25mV
  input wire breaker_pkg::chan_t i_fast_over, // sense above 100mV
  input wire logic i_fault_pin_low, // fault pin comparator sees a low
  output logic o_fault_out, // fault pin driven value (always low)
  output logic o_fault_oe, // fault pin pull-down enable
  output logic o_gate_enable, // gate drive allowed for both channels
  output logic o_integ_active, // integrator charging
  output logic o_tripped // breaker latch state
);
  import breaker_pkg::*;

  // whole state of the breaker in one record
  typedef struct packed {
    brk_state_t st;
    logic slow_armed;
    logic [19:0] integ;
    logic tripped;
  } cb_state_t;
  cb_state_t s_reg;
  cb_state_t s_next;

  logic [1:0] ov_hit; // per-channel filtered overvoltage
  logic [1:0] slow_hit; // per-channel slow persistence
  logic [1:0] fast_hit; // per-channel fast persistence
  logic ext_hit; // filtered external fault
  logic rst_hit; // filtered reset request
  logic armed; // breaker armed
  logic any_slow; // any slow overcurrent once the slow detectors are armed
  logic trip_now; // any trip cause this cycle
  logic integ_full; // integrator at or past its trip level

  assign armed = (s_reg.st == ST_ARMED);

  // per-channel filters for overvoltage, slow and fast detectors
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      // overvoltage filter, cleared while the breaker is disarmed
      persist_filter #(.LIMIT(OV_CNT)) u_ov (
        .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_clear(!armed),
        .i_cond(i_fb_over[g]), .o_hit(ov_hit[g]));
      // slow filter, held clear until the start-up loop lets go
      persist_filter #(.LIMIT(SLOW_CNT)) u_slow (
        .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_clear(!s_reg.slow_armed),
        .i_cond(i_slow_over[g]), .o_hit(slow_hit[g]));
      // fast filter, live from the end of the initial cycle
      persist_filter #(.LIMIT(FAST_CNT)) u_fast (
        .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_clear(!armed),
        .i_cond(i_fast_over[g]), .o_hit(fast_hit[g]));
    end
  endgenerate

  // external pull-down filter, blind to our own drive
  persist_filter #(.LIMIT(FLT_CNT)) u_ext (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_clear(!armed),
    .i_cond(i_fault_pin_low), .o_hit(ext_hit));

  // reset pin must stay low beyond the filter time
  // never cleared, so a trip cannot block its own release
  persist_filter #(.LIMIT(RST_CNT)) u_rst (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_clear(1'b0),
    .i_cond(i_master_enable_reset_low), .o_hit(rst_hit));

  // integrator charges only once the slow detectors are armed
  assign any_slow = s_reg.slow_armed && (|i_slow_over);
  // integrator reached its trip level
  assign integ_full = (s_reg.integ >= 20'(INTEG_TRIP));
  // any filtered cause trips, but only while armed
  assign trip_now = armed && ((|ov_hit) || (|fast_hit) || ext_hit
                    || (|slow_hit) || integ_full);

  // sequencing, integrator and trip latch
  always_comb begin
    s_next = s_reg;
    case (s_reg.st)
      ST_RESET: begin
        // waits in off state until reset released
        s_next.tripped = 1'b0;
        s_next.slow_armed = 1'b0;
        s_next.integ = '0;
        if (!i_master_enable_reset_low) begin
          s_next.st = ST_INIT;
        end
      end
      ST_INIT: begin
        // detectors held clear until the initial cycle ends
        if (i_init_done) begin
          s_next.st = ST_ARMED;
        end
      end
      ST_ARMED: begin
        // protected start-up: fast, overvoltage and pin live
        if (i_startup_done) begin
          s_next.slow_armed = 1'b1;
        end
        if (any_slow) begin
          s_next.integ = s_reg.integ + 20'(`INTEG_UP);
        end else if (s_reg.integ != '0) begin
          s_next.integ = s_reg.integ - 20'(`INTEG_DOWN);
        end
        if (trip_now) begin
          s_next.st = ST_TRIPPED;
          s_next.tripped = 1'b1;
          s_next.integ = '0;
          s_next.slow_armed = 1'b0;
        end
      end
      ST_TRIPPED: begin
        // latch holds, integrator held low until reset
        s_next.integ = '0;
        s_next.tripped = 1'b1;
      end
      default: begin
        // unused code falls back to the safe reset state
        s_next.st = ST_RESET;
      end
    endcase
    // filtered reset clears from any state
    if (rst_hit) begin
      s_next.st = ST_RESET;
      s_next.tripped = 1'b0;
      s_next.slow_armed = 1'b0;
      s_next.integ = '0;
    end
  end

  // state register
  // async reset lands in the off state with the latch clear
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_reg <= '{st: ST_RESET, slow_armed: 1'b0, integ: '0, tripped: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs from state; integrator activity also follows the slow inputs
  assign o_fault_out = 1'b0;
  assign o_fault_oe = s_reg.tripped;
  assign o_gate_enable = armed && !s_reg.tripped;
  assign o_integ_active = any_slow;
  assign o_tripped = s_reg.tripped;

  // checks
  // a latched trip keeps both gates off and the pin pulled
  trip_gates_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    o_tripped |-> !o_gate_enable && o_fault_oe) else $error("gates on during trip");
  // any cause while armed latches at the next edge
  trip_next_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    trip_now && !rst_hit |=> o_tripped) else $error("trip not latched");
  // fast detector of channel 0 trips
  fast_trip_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    armed && fast_hit[0] && !rst_hit |=> o_tripped) else $error("fast miss");
  // overvoltage of channel 1 trips
  ov_trip_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    armed && ov_hit[1] && !rst_hit |=> o_tripped) else $error("ov miss");
  // filtered external pull-down trips
  ext_trip_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    armed && ext_hit && !rst_hit |=> o_tripped) else $error("ext miss");
  // slow detector of channel 1 trips
  slow_trip_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    armed && slow_hit[1] && !rst_hit |=> o_tripped) else $error("slow miss");
  // integrator past its level trips and is cleared
  integ_trip_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    armed && integ_full && !rst_hit |=> o_tripped && s_reg.integ == '0)
    else $error("integrator trip miss");
  // slow detectors idle outside the armed state
  slow_idle_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    s_reg.st != ST_ARMED |-> !s_reg.slow_armed) else $error("slow armed out of state");
  // integrator quiet before the slow detectors arm
  slow_gate_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    !s_reg.slow_armed |-> !o_integ_active) else $error("slow early");
  // integrator climbs at its charge step
  integ_up_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    any_slow && !trip_now && !rst_hit && armed |=> s_reg.integ == $past(s_reg.integ)
    + 20'(`INTEG_UP)) else $error("integrator not rising");
  // integrator bleeds down while both channels are quiet
  integ_down_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    armed && !any_slow && s_reg.integ != '0 && !trip_now && !rst_hit
    |=> s_reg.integ == $past(s_reg.integ) - 20'(`INTEG_DOWN))
    else $error("integrator not falling");
  // no trip and fast detectors clear before the initial cycle ends
  init_hold_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    s_reg.st == ST_INIT |=> !o_tripped && fast_hit == '0)
    else $error("trip before arming");
  // filtered reset clears the latch
  reset_clear_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    rst_hit |=> !o_tripped && s_reg.st == ST_RESET) else $error("reset no clear");
  // pin released once the latch is clear
  pull_release_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    !o_tripped |-> !o_fault_oe) else $error("pin pulled without trip");
  // gates stay off coming out of reset
  unarmed_safe_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    s_reg.st == ST_RESET |=> !o_gate_enable) else $error("gate on in reset");
  // reset release moves to the off, timing state
  release_off_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    s_reg.st == ST_RESET && !i_master_enable_reset_low && !rst_hit
    |=> s_reg.st == ST_INIT && !o_gate_enable && !o_tripped)
    else $error("no clean release");
  // main scenarios seen
  trip_seen_c: cover property (@(posedge i_mclk) disable iff (!i_arst_n) $rose(o_tripped));
  retry_c: cover property (@(posedge i_mclk) disable iff (!i_arst_n) $fell(o_tripped));
  slow_arm_c: cover property (@(posedge i_mclk) disable iff (!i_arst_n) $rose(s_reg.slow_armed));
  ext_trip_c: cover property (@(posedge i_mclk) disable iff (!i_arst_n)
    armed && ext_hit);
  integ_trip_c: cover property (@(posedge i_mclk) disable iff (!i_arst_n)
    armed && integ_full);
endmodule
`default_nettype wire

// ### core/breaker_cfg.svh
// constants for the two-channel circuit breaker
`ifndef BREAKER_CFG_SVH
`define BREAKER_CFG_SVH
`define CLK_PERIOD_NS 10
`define OV_FILTER_NS 18000
`define FAULT_FILTER_NS 15000
`define SLOW_DELAY_NS 15000
`define FAST_DELAY_NS 1000
`define RESET_FILTER_NS 15000
`define OV_CYCLES ((`OV_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FAULT_CYCLES ((`FAULT_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLOW_CYCLES ((`SLOW_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FAST_CYCLES ((`FAST_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_CYCLES ((`RESET_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INTEG_UP 58
`define INTEG_DOWN 1
`define INTEG_TRIP 100000
`endif

// ### core/breaker_pkg.sv
// types shared by the circuit breaker design
package breaker_pkg;
  typedef enum logic [1:0] {ST_RESET, ST_INIT, ST_ARMED, ST_TRIPPED} brk_state_t;
  typedef logic [1:0] chan_t;
endpackage

// ### core/persist_filter.sv
// counts cycles a condition holds and flags once it outlasts a limit
`timescale 1ns/1ps
`default_nettype none
module persist_filter #(
  parameter int LIMIT = 100
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_clear,
  input wire logic i_cond,
  output logic o_hit
);
  typedef struct packed {
    logic [19:0] cnt;
    logic hit;
  } pf_state_t;
  pf_state_t s_reg;
  pf_state_t s_next;

  // counter restarts whenever the condition drops
  always_comb begin
    s_next = s_reg;
    if (i_clear || !i_cond) begin
      s_next.cnt = '0;
      s_next.hit = 1'b0;
    end else if (s_reg.cnt >= 20'(LIMIT)) begin
      s_next.hit = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 20'h0_0001;
    end
  end

  // state register
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_hit = s_reg.hit;
endmodule
`default_nettype wire

// ### verification/board_model.sv
// outside board: fault pin wire, external pull-down and autoretry tie
`timescale 1ns/1ps
`default_nettype none
module board_model (
  input wire logic i_fault_oe, // device pull-down enable
  input wire logic i_fault_out, // device driven level
  input wire logic i_ext_pull, // outside party pulls pin low
  input wire logic i_loop, // pin tied to enable inputs
  input wire logic i_reset_req, // outside party drives enable low
  output logic o_pin_low, // pin level seen by comparator
  output logic o_enable_low // enable below reset level
);
  // weak pull-up wins unless someone pulls down
  assign o_pin_low = (i_fault_oe && !i_fault_out) || i_ext_pull;
  // autoretry: enable follows the pin
  assign o_enable_low = i_reset_req || (i_loop && o_pin_low);
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench for the two-channel breaker
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import breaker_pkg::*;
  localparam int lim [4] = '{100, 15, 20, 15}; // fast (1us at 10ns), slow, overvoltage, pin
  localparam int rst_cnt = 15; // reset filter length
  logic i_mclk = 1'b0;
  logic i_arst_n = 1'b0;
  logic init_done = 1'b0, startup_done = 1'b0, ext_pull = 1'b0;
  logic loop_on = 1'b0, reset_req = 1'b0;
  chan_t fb_over = '0, slow_over = '0, fast_over = '0;
  logic pin_low, enable_low, fault_out, fault_oe, gate_enable, integ_active, tripped;
  int miscompares = 0, total_checks = 0, cycles = 0;
  logic [31:0] seed = 32'h7531_d11a;
  // free-running clock
  always #5 i_mclk = ~i_mclk;
  // fast filter at its 1us default; integrator level above the 15-cycle slow filter
  circuit_breaker #(.OV_CNT(20), .FLT_CNT(15), .SLOW_CNT(15),
    .RST_CNT(15), .INTEG_TRIP(1160)) circuit_breaker_inst (.i_mclk(i_mclk),
    .i_arst_n(i_arst_n), .i_master_enable_reset_low(enable_low),
    .i_init_done(init_done), .i_startup_done(startup_done), .i_fb_over(fb_over),
    .i_slow_over(slow_over), .i_fast_over(fast_over), .i_fault_pin_low(pin_low),
    .o_fault_out(fault_out), .o_fault_oe(fault_oe), .o_gate_enable(gate_enable),
    .o_integ_active(integ_active), .o_tripped(tripped));
  board_model board_model_inst (.i_fault_oe(fault_oe), .i_fault_out(fault_out),
    .i_ext_pull(ext_pull), .i_loop(loop_on), .i_reset_req(reset_req),
    .o_pin_low(pin_low), .o_enable_low(enable_low));
  // xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic complete_run();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  // one condition source per kind
  task automatic apply(input int kind, input int ch, input logic v);
    case (kind)
      0: fast_over[ch] = v;
      1: slow_over[ch] = v;
      2: fb_over[ch] = v;
      default: ext_pull = v;
    endcase
  endtask
  task automatic arm(input logic slow_on);
    tick(3);
    init_done = 1'b1;
    tick(1);
    init_done = 1'b0;
    startup_done = slow_on;
    tick(2);
    check(gate_enable, 1'b1, "gate off after arming");
  endtask
  task automatic clear_trip();
    startup_done = 1'b0;
    reset_req = 1'b1;
    tick(rst_cnt + 3);
    check(tripped, 1'b0, "latch not cleared");
    check(fault_oe, 1'b0, "pin still pulled");
    reset_req = 1'b0;
    tick(2);
    check(gate_enable, 1'b0, "gate on before new cycle");
  endtask
  task automatic trip_run(input int kind, input int ch);
    int n;
    n = 0;
    // slow path skipped: no short-pulse check on the slow filter
    if (kind != 1) begin
      apply(kind, ch, 1'b1);
      tick(lim[kind] - 2);
      apply(kind, ch, 1'b0);
      tick(3);
      check(tripped, 1'b0, "short pulse tripped");
    end
    apply(kind, ch, 1'b1);
    while (tripped !== 1'b1 && n < lim[kind] + 4) begin
      tick(1);
      n++;
    end
    apply(kind, ch, 1'b0);
    check(tripped, 1'b1, "no trip");
    check(logic'(n >= lim[kind] - 1), 1'b1, "trip too early");
    check(gate_enable, 1'b0, "gate not off");
    check(fault_oe & ~fault_out, 1'b1, "pin not pulled");
    clear_trip();
  endtask
  // duty burst on a random channel, stops at trip
  task automatic bursts(input int base);
    int ch;
    repeat (40) begin
      if (tripped === 1'b1) break;
      ch = int'(rnd() % 2);
      slow_over[ch] = 1'b1;
      tick(1);
      check(integ_active, 1'b1, "integrator idle");
      slow_over[ch] = 1'b0;
      if (tripped !== 1'b1) tick(base + int'(rnd() % 10));
    end
  endtask
  // hang guard
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    tick(12);
    i_arst_n = 1'b1;
    fast_over = 2'b01;
    tick(lim[0] + 10);
    check(tripped, 1'b0, "tripped while unarmed");
    fast_over = 2'b00;
    arm(1'b0);
    slow_over = 2'b11;
    tick(40);
    check(tripped | integ_active, 1'b0, "slow armed early");
    slow_over = 2'b00;
    startup_done = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (i > 0) arm(1'b1);
      trip_run(i / 2, (i % 2) ^ int'(rnd() % 2));
    end
    arm(1'b1);
    bursts(15);
    check(tripped, 1'b1, "duty overload kept running");
    clear_trip();
    arm(1'b1);
    bursts(70);
    check(tripped, 1'b0, "low duty tripped");
    loop_on = 1'b1;
    fast_over = 2'b10;
    tick(lim[0] + 4);
    fast_over = 2'b00;
    check(tripped, 1'b1, "loop no trip");
    tick(rst_cnt + 4);
    check(tripped, 1'b0, "autoretry stuck");
    complete_run();
  end
endmodule
`default_nettype wire
